// File: sepd_pkg.sv
// shared constants for the safe encoder process data link
package sepd_pkg;
   localparam int BYTE_W = 8;
   localparam int CTRL_W = 16;
   localparam int STAT_W = 16;
   localparam int VEL_W = 16;
   localparam int POS_W = 32;
   localparam int PRESET_W = 32;
   // host output frame: control word then preset word
   localparam logic [3:0] HOST_BYTES = 4'h6;
   // device input frame, long with velocity, short without
   localparam logic [3:0] DEV_BYTES_LONG = 4'h8;
   localparam logic [3:0] DEV_BYTES_SHORT = 4'h6;
   // control word bit positions
   localparam int CTL_PRESET_EN = 0;
   localparam int CTL_PRESET_TRIG = 6;
   // status word bit positions
   localparam int ST_POS_VALID = 0;
   localparam int ST_VEL_VALID = 1;
   localparam int ST_PRESET_EN = 2;
   localparam int ST_PRESET_ERR = 5;
   localparam int ST_PRESET_ACK = 6;
   localparam int ST_INT_EVENT = 7;
   // velocity normalisation units
   localparam logic [1:0] VEL_STEPS_SEC = 2'h0;
   localparam logic [1:0] VEL_STEPS_100MS = 2'h1;
   localparam logic [1:0] VEL_STEPS_10MS = 2'h2;
   localparam logic [1:0] VEL_RPM = 2'h3;
   // reset values
   localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
   localparam logic [STAT_W-1:0] STAT_RESET = 16'h0000;
   localparam logic [POS_W-1:0] OFFSET_RESET = 32'h0000_0000;
   typedef enum logic [1:0]
   {
      PS_ARMED = 2'b00,
      PS_TWO = 2'b01,
      PS_THREE = 2'b10,
      PS_FAIL = 2'b11
   } sepd_preset_type;
endpackage : sepd_pkg

// File: sepd_link_if.sv
// byte link between host controller and encoder
interface sepd_link_if;
   logic hostValid;
   logic [7:0] hostData;
   logic devValid;
   logic [7:0] devData;
   modport device
   (
      input hostValid,
      input hostData,
      output devValid,
      output devData
   );
   modport host
   (
      output hostValid,
      output hostData,
      input devValid,
      input devData
   );
endinterface : sepd_link_if

// File: sepd_device.sv
// encoder end: safe position, velocity, preset and status words
//
// Operation
// R01: position sent only when error-free and available
// R02: position signed 32-bit, most significant byte first
// R03: position scaled only by individual safety parameters
// R04: axis type and scaling readable as status
// R05: status bit 0 marks position valid
// R06: velocity sent only valid, signed 16-bit, high first
// R07: status bit 1 marks velocity valid
// R08: velocity normalised only by safety unit setting
// R09: control bit 0 enables preset
// R10: rising trigger bit 6 loads preset position
// R11: trigger back to zero rearms preset
// R12: status bit 2 echoes preset enable
// R13: failed preset sets bit 5, not bit 7
// R14: status bit 6 acknowledges preset taken over
// R15: host sends preset word, most significant first
// R16: preset unit equals one position step
// R17: long telegram: status, velocity, position; control, preset
// R18: short telegram: status, position; control, preset
// R19: reserved control and status bits zero, ignored
module sepd_device #(
   parameter int RANGE_W = 30,
   parameter int STEPS_W = 14
)
(
   input wire logic clk_sys,
   input wire logic srst,
   sepd_link_if.device link,
   input wire logic longTelegram,
   input wire logic [RANGE_W-1:0] totalRange,
   input wire logic [STEPS_W-1:0] stepsPerRev,
   input wire logic axisType,
   input wire logic scalingEnable,
   input wire logic [1:0] velocityUnit,
   input wire logic [31:0] scaledPosition,
   input wire logic positionFault,
   input wire logic signed [31:0] rawVelocity,
   input wire logic velocityFault,
   input wire logic internalEvent,
   output logic [RANGE_W+STEPS_W+1:0] safeOperatingStatus,
   output logic presetTaken
);
   if (RANGE_W < 2 || RANGE_W > 31 || STEPS_W < 2 || STEPS_W > 16)
   begin : gen_width_check
      $error("sepd_device: unsupported width");
   end

   ////////////////////////////////////////////////////////////////////////
   // velocity normalisation, bit 16 flags overflow
   function automatic logic [16:0] normVelocity(
      input logic signed [31:0] raw,
      input logic [1:0] unitSel,
      input logic [STEPS_W-1:0] steps
   );
      logic signed [47:0] wide;
      wide = 48'(raw);
      case (unitSel)
         sepd_pkg::VEL_STEPS_SEC: wide = wide;
         sepd_pkg::VEL_STEPS_100MS: wide = wide / 48'sd10;
         sepd_pkg::VEL_STEPS_10MS: wide = wide / 48'sd100;
         sepd_pkg::VEL_RPM:
            wide = (wide * 48'sd60) / $signed(48'(steps));
         default: wide = wide;
      endcase
      normVelocity[15:0] = wide[15:0];
      normVelocity[16] = !(&wide[47:15] || ~|wide[47:15]);
   endfunction : normVelocity

   ////////////////////////////////////////////////////////////////////////
   // receive control and preset words
   logic [3:0] rxCount_r;
   logic [47:0] rxShift_r;
   logic rxDone_r;
   logic [15:0] ctrlWord_r;
   logic [31:0] presetWord_r;
   logic [47:0] rxShiftNxt;

   assign rxShiftNxt = {rxShift_r[39:0], link.hostData};

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         rxCount_r <= 4'h0;
         rxShift_r <= 48'h0000_0000_0000;
         rxDone_r <= 1'b0;
      end
      else
      begin
         rxDone_r <= 1'b0;
         if (link.hostValid)
         begin
            rxShift_r <= rxShiftNxt;
            if (rxCount_r == sepd_pkg::HOST_BYTES - 4'h1)
            begin
               rxCount_r <= 4'h0;
               rxDone_r <= 1'b1;
            end
            else
               rxCount_r <= rxCount_r + 4'h1;
         end
      end
   end

   // words arrive most significant byte first
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         ctrlWord_r <= sepd_pkg::CTRL_RESET;
         presetWord_r <= 32'h0000_0000;
      end
      else if (rxDone_r)
      begin
         // R19
         ctrlWord_r <= rxShift_r[47:32]
            & 16'((1 << sepd_pkg::CTL_PRESET_EN)
            | (1 << sepd_pkg::CTL_PRESET_TRIG));
         presetWord_r <= rxShift_r[31:0]; // R15 R16
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // preset sequence, evaluated once per received frame
   sepd_pkg::sepd_preset_type presetState_r;
   logic applyCtrl_r;
   logic trigPrev_r;
   logic [31:0] offset_r;
   logic presetEn;
   logic presetTrig;

   assign presetEn = ctrlWord_r[sepd_pkg::CTL_PRESET_EN]; // R09
   assign presetTrig = ctrlWord_r[sepd_pkg::CTL_PRESET_TRIG];

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         applyCtrl_r <= 1'b0;
      else
         applyCtrl_r <= rxDone_r;
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         presetState_r <= sepd_pkg::PS_ARMED;
         trigPrev_r <= 1'b0;
         offset_r <= sepd_pkg::OFFSET_RESET;
      end
      else if (applyCtrl_r)
      begin
         trigPrev_r <= presetTrig;
         case (presetState_r)
            sepd_pkg::PS_ARMED:
               if (presetEn && presetTrig && !trigPrev_r) // R10
                  presetState_r <= sepd_pkg::PS_TWO;
            sepd_pkg::PS_TWO:
               // R13
               if (positionFault
                  || presetWord_r >= 32'(totalRange))
                  presetState_r <= sepd_pkg::PS_FAIL;
               else
               begin
                  offset_r <= presetWord_r + 32'(totalRange)
                     - scaledPosition % 32'(totalRange); // R10 R16
                  presetState_r <= sepd_pkg::PS_THREE;
               end
            sepd_pkg::PS_THREE,
            sepd_pkg::PS_FAIL:
               if (!presetTrig || !presetEn) // R11
                  presetState_r <= sepd_pkg::PS_ARMED;
            default: presetState_r <= sepd_pkg::PS_ARMED;
         endcase
      end
   end

   assign presetTaken = (presetState_r == sepd_pkg::PS_THREE);

   ////////////////////////////////////////////////////////////////////////
   // safe values and status word
   logic [16:0] velNorm;
   logic posValid;
   logic velValid;
   logic [31:0] safePos;
   logic [15:0] statusWord;

   assign velNorm = normVelocity(rawVelocity, velocityUnit, stepsPerRev); // R08
   assign posValid = !positionFault; // R01
   assign velValid = !velocityFault && !velNorm[16]; // R06
   assign safePos = 32'((34'(scaledPosition % 32'(totalRange))
      + 34'(offset_r)) % 34'(totalRange)); // R03

   always_comb
   begin
      statusWord = sepd_pkg::STAT_RESET; // R19
      statusWord[sepd_pkg::ST_POS_VALID] = posValid; // R05
      statusWord[sepd_pkg::ST_VEL_VALID] = velValid; // R07
      statusWord[sepd_pkg::ST_PRESET_EN] = presetEn; // R12
      // R13
      statusWord[sepd_pkg::ST_PRESET_ERR] =
         (presetState_r == sepd_pkg::PS_FAIL);
      // R14
      statusWord[sepd_pkg::ST_PRESET_ACK] =
         (presetState_r == sepd_pkg::PS_THREE);
      statusWord[sepd_pkg::ST_INT_EVENT] = internalEvent; // R13
   end

   // R04
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         safeOperatingStatus <= '0;
      else
         safeOperatingStatus <= {axisType, scalingEnable, totalRange,
            stepsPerRev};
   end

   ////////////////////////////////////////////////////////////////////////
   // reply frame, one cycle after the preset step
   logic loadTx_r;
   logic [3:0] txCount_r;
   logic [63:0] txShift_r;
   logic devValid_r;
   logic [7:0] devData_r;

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         loadTx_r <= 1'b0;
      else
         loadTx_r <= applyCtrl_r;
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         txCount_r <= 4'h0;
         txShift_r <= 64'h0000_0000_0000_0000;
         devValid_r <= 1'b0;
         devData_r <= 8'h00;
      end
      else if (loadTx_r)
      begin
         // R02 R06 R17 R18
         if (longTelegram)
         begin
            txShift_r <= {statusWord,
               velValid ? velNorm[15:0] : 16'h0000,
               posValid ? safePos : 32'h0000_0000};
            txCount_r <= sepd_pkg::DEV_BYTES_LONG;
         end
         else
         begin
            txShift_r <= {statusWord,
               posValid ? safePos : 32'h0000_0000, 16'h0000};
            txCount_r <= sepd_pkg::DEV_BYTES_SHORT;
         end
         devValid_r <= 1'b0;
      end
      else if (txCount_r != 4'h0)
      begin
         devValid_r <= 1'b1;
         devData_r <= txShift_r[63:56];
         txShift_r <= {txShift_r[55:0], 8'h00};
         txCount_r <= txCount_r - 4'h1;
      end
      else
         devValid_r <= 1'b0;
   end

   assign link.devValid = devValid_r;
   assign link.devData = devData_r;
endmodule : sepd_device

// File: sepd_host.sv
// controller end: sends control and preset, gathers encoder words
module sepd_host
(
   input wire logic clk_sys,
   input wire logic srst,
   sepd_link_if.host link,
   input wire logic longTelegram,
   input wire logic cycleStart,
   input wire logic presetEnable,
   input wire logic presetTrigger,
   input wire logic [31:0] presetValue,
   output logic busy,
   output logic cycleDone,
   output logic [15:0] statusWord,
   output logic [15:0] velocityWord,
   output logic [31:0] positionWord
);
   ////////////////////////////////////////////////////////////////////////
   // send control then preset, most significant byte first
   logic [3:0] txCount_r;
   logic [47:0] txShift_r;
   logic hostValid_r;
   logic [7:0] hostData_r;
   logic waitReply_r;
   logic [15:0] ctrlOut;

   always_comb
   begin
      ctrlOut = sepd_pkg::CTRL_RESET; // R19
      ctrlOut[sepd_pkg::CTL_PRESET_EN] = presetEnable; // R09
      ctrlOut[sepd_pkg::CTL_PRESET_TRIG] = presetTrigger; // R11
   end

   assign busy = (txCount_r != 4'h0) || waitReply_r;

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         txCount_r <= 4'h0;
         txShift_r <= 48'h0000_0000_0000;
         hostValid_r <= 1'b0;
         hostData_r <= 8'h00;
      end
      else if (cycleStart && !busy)
      begin
         txShift_r <= {ctrlOut, presetValue}; // R15 R17 R18
         txCount_r <= sepd_pkg::HOST_BYTES;
         hostValid_r <= 1'b0;
      end
      else if (txCount_r != 4'h0)
      begin
         hostValid_r <= 1'b1;
         hostData_r <= txShift_r[47:40];
         txShift_r <= {txShift_r[39:0], 8'h00};
         txCount_r <= txCount_r - 4'h1;
      end
      else
         hostValid_r <= 1'b0;
   end

   assign link.hostValid = hostValid_r;
   assign link.hostData = hostData_r;

   ////////////////////////////////////////////////////////////////////////
   // gather reply bytes
   logic [3:0] rxCount_r;
   logic [63:0] rxShift_r;
   logic [3:0] rxLast;
   logic [63:0] rxShiftNxt;

   assign rxLast = longTelegram ? sepd_pkg::DEV_BYTES_LONG - 4'h1
      : sepd_pkg::DEV_BYTES_SHORT - 4'h1;
   assign rxShiftNxt = {rxShift_r[55:0], link.devData};

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         waitReply_r <= 1'b0;
         rxCount_r <= 4'h0;
         rxShift_r <= 64'h0000_0000_0000_0000;
         cycleDone <= 1'b0;
         statusWord <= sepd_pkg::STAT_RESET;
         velocityWord <= 16'h0000;
         positionWord <= 32'h0000_0000;
      end
      else
      begin
         cycleDone <= 1'b0;
         if (cycleStart && !busy)
         begin
            waitReply_r <= 1'b1;
            rxCount_r <= 4'h0;
         end
         else if (link.devValid && waitReply_r)
         begin
            rxShift_r <= rxShiftNxt;
            if (rxCount_r == rxLast)
            begin
               waitReply_r <= 1'b0;
               cycleDone <= 1'b1;
               // R02 R17 R18 R19
               if (longTelegram)
               begin
                  statusWord <= rxShiftNxt[63:48] & 16'h00E7;
                  velocityWord <= rxShiftNxt[47:32];
                  positionWord <= rxShiftNxt[31:0];
               end
               else
               begin
                  statusWord <= rxShiftNxt[47:32] & 16'h00E7;
                  velocityWord <= 16'h0000;
                  positionWord <= rxShiftNxt[31:0];
               end
            end
            else
               rxCount_r <= rxCount_r + 4'h1;
         end
      end
   end
endmodule : sepd_host

// File: sepd_link_properties.sv
// concurrent checks on the encoder byte link
module sepd_link_properties
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic hostValid,
   input wire logic [7:0] hostData,
   input wire logic devValid,
   input wire logic [7:0] devData
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////////////
   chk_host_frame_len: assert property (
      $rose(hostValid) |-> hostValid [*6] ##1 !hostValid)
      else $error("host frame length wrong");
   chk_reply_start: assert property (
      $fell(hostValid) |-> !devValid [*4] ##1 devValid)
      else $error("reply not started on time");
   chk_reply_len: assert property (
      $rose(devValid) |-> devValid [*6] ##1
      (!devValid or devValid [*2] ##1 !devValid))
      else $error("reply length wrong");
   chk_no_overlap: assert property (
      !(hostValid && devValid))
      else $error("both directions active");
   chk_status_high: assert property (
      $rose(devValid) |-> devData == 8'h00)
      else $error("status high byte not zero");
   chk_status_rsvd: assert property (
      $rose(devValid) |=> devData[4:3] == 2'h0)
      else $error("status reserved bits set");
   chk_ctrl_high: assert property (
      $rose(hostValid) |-> hostData == 8'h00)
      else $error("control high byte not zero");
   chk_ctrl_rsvd: assert property (
      $rose(hostValid) |=> (hostData & 8'hBE) == 8'h00)
      else $error("control reserved bits set");
   chk_enable_echo: assert property (
      $rose(hostValid) |-> ##11 devData[2] == $past(hostData[0], 10))
      else $error("enable not echoed");
endmodule : sepd_link_properties

// File: tb.sv
// self-checking bench for both ends of the encoder link
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic longTelegram = 1'b1;
   logic [29:0] totalRange = 30'h0010_0000;
   logic [13:0] stepsPerRev = 14'h0FA0;
   logic axisType = 1'b1;
   logic scalingEnable = 1'b0;
   logic [1:0] velocityUnit = 2'h0;
   logic [31:0] scaledPosition = 32'h0001_2345;
   logic positionFault = 1'b0;
   logic signed [31:0] rawVelocity = 32'hFFFF_E890;
   logic velocityFault = 1'b0;
   logic internalEvent = 1'b0;
   logic [45:0] safeOperatingStatus;
   logic presetTaken;
   logic cycleStart = 1'b0;
   logic presetEnable = 1'b0;
   logic presetTrigger = 1'b0;
   logic [31:0] presetValue = 32'h0;
   logic busy;
   logic cycleDone;
   logic [15:0] statusWord;
   logic [15:0] velocityWord;
   logic [31:0] positionWord;
   logic [7:0] hb [8];
   logic [7:0] db [8];
   int nh = 0;
   int nd = 0;
   int cyc = 0;
   int errCount = 0;
   int checked = 0;
   ////////////////////////////////////////////////////////////////////////
   always #2 clk_sys = ~clk_sys;
   sepd_link_if sepd_link_if_i ();
   sepd_device sepd_device_i (.clk_sys, .srst, .link(sepd_link_if_i),
      .longTelegram, .totalRange, .stepsPerRev, .axisType,
      .scalingEnable, .velocityUnit, .scaledPosition, .positionFault,
      .rawVelocity, .velocityFault, .internalEvent,
      .safeOperatingStatus, .presetTaken);
   sepd_host sepd_host_i (.clk_sys, .srst, .link(sepd_link_if_i),
      .longTelegram, .cycleStart, .presetEnable, .presetTrigger,
      .presetValue, .busy, .cycleDone, .statusWord, .velocityWord,
      .positionWord);
   sepd_link_properties sepd_link_properties_i (.clk_sys, .srst,
      .hostValid(sepd_link_if_i.hostValid),
      .hostData(sepd_link_if_i.hostData),
      .devValid(sepd_link_if_i.devValid),
      .devData(sepd_link_if_i.devData));
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk_sys)
   begin
      cyc = cyc + 1;
      if (sepd_link_if_i.hostValid === 1'b1 && nh < 8)
      begin
         hb[nh] = sepd_link_if_i.hostData;
         nh = nh + 1;
      end
      if (sepd_link_if_i.devValid === 1'b1 && nd < 8)
      begin
         db[nd] = sepd_link_if_i.devData;
         nd = nd + 1;
      end
      if (cyc == 3000)
      begin
         errCount = errCount + 1;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checked %0d mismatches %0d", checked, errCount);
      if (errCount == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         errCount++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   ////////////////////////////////////////////////////////////////////////
   task automatic frame(input logic en, input logic trig,
      input logic [31:0] pv, input logic [15:0] es, input logic [31:0] ep);
      int n;
      int off;
      logic [15:0] m;
      @(negedge clk_sys);
      presetEnable = en;
      presetTrigger = trig;
      presetValue = pv;
      nh = 0;
      nd = 0;
      cycleStart = 1'b1;
      n = 0;
      off = longTelegram ? 4 : 2;
      m = longTelegram ? 16'hFFFF : 16'hFFFD;
      while (cycleDone !== 1'b1 && n < 40)
      begin
         @(negedge clk_sys);
         cycleStart = (n == 3);
         n++;
      end
      chk("done", 1, {busy, cycleDone});
      chk("host bytes", 6, nh);
      chk("ctrl wire", {trig, 5'h00, en}, {hb[0], hb[1]});
      chk("preset wire", pv, {hb[2], hb[3], hb[4], hb[5]});
      chk("reply bytes", off + 4, nd);
      chk("status", es & m, statusWord & m);
      chk("status wire", es & m, {db[0], db[1]} & m);
      chk("position", ep, positionWord);
      chk("pos wire", ep, {db[off], db[off+1], db[off+2], db[off+3]});
   endtask : frame
   task automatic vel(input logic [1:0] u, input logic [31:0] raw,
      input logic [15:0] ev, input logic [15:0] es);
      velocityUnit = u;
      rawVelocity = raw;
      frame(0, 0, 32'h0, es, scaledPosition);
      chk("velocity", ev, velocityWord);
      chk("vel wire", ev, {db[2], db[3]});
   endtask : vel
   ////////////////////////////////////////////////////////////////////////
   task automatic run_basic();
      frame(0, 0, 32'h0, 16'h0003, scaledPosition);
      chk("op range", totalRange, safeOperatingStatus[43:14]);
      chk("op flags", {axisType, scalingEnable, stepsPerRev},
         {safeOperatingStatus[45:44], safeOperatingStatus[13:0]});
   endtask : run_basic
   task automatic run_velocity();
      vel(2'h0, 32'hFFFF_E890, 16'hE890, 16'h0003);
      vel(2'h1, 32'hFFFF_E890, 16'hFDA8, 16'h0003);
      vel(2'h2, 32'hFFFF_E890, 16'hFFC4, 16'h0003);
      vel(2'h3, 32'hFFFF_E890, 16'hFFA6, 16'h0003);
      vel(2'h0, 32'h0000_9C40, 16'h0000, 16'h0001);
   endtask : run_velocity
   task automatic run_faults();
      rawVelocity = 32'h0000_1770;
      positionFault = 1'b1;
      internalEvent = 1'b1;
      frame(0, 0, 32'h0, 16'h0082, 32'h0);
      positionFault = 1'b0;
      internalEvent = 1'b0;
      longTelegram = 1'b0;
      frame(0, 0, 32'h0, 16'h0001, scaledPosition);
      chk("short vel", 16'h0, velocityWord);
      longTelegram = 1'b1;
   endtask : run_faults
   task automatic run_preset();
      frame(1, 0, 32'h500, 16'h0007, scaledPosition);
      frame(1, 1, 32'h500, 16'h0007, scaledPosition);
      frame(1, 1, 32'h500, 16'h0047, 32'h500);
      chk("taken", 1, presetTaken);
      frame(1, 0, 32'h500, 16'h0007, 32'h500);
      frame(1, 1, 32'h800, 16'h0007, 32'h500);
      frame(1, 1, 32'h800, 16'h0047, 32'h800);
   endtask : run_preset
   task automatic run_disabled();
      frame(0, 0, 32'h0, 16'h0003, 32'h800);
      frame(0, 1, 32'h900, 16'h0003, 32'h800);
      frame(0, 1, 32'h900, 16'h0003, 32'h800);
      frame(0, 0, 32'h0, 16'h0003, 32'h800);
   endtask : run_disabled
   task automatic run_preset_fail();
      frame(1, 1, 32'h0020_0000, 16'h0007, 32'h800);
      frame(1, 1, 32'h0020_0000, 16'h0027, 32'h800);
      frame(1, 0, 32'h0, 16'h0007, 32'h800);
   endtask : run_preset_fail
   task automatic run_reset();
      @(negedge clk_sys);
      srst = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk("reset status", 32'h0, {busy, cycleDone, statusWord});
      chk("reset taken", 32'h0, presetTaken);
      srst = 1'b0;
      frame(0, 0, 32'h0, 16'h0003, scaledPosition);
   endtask : run_reset
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (16) @(negedge clk_sys);
      srst = 1'b0;
      run_basic();
      run_velocity();
      run_faults();
      run_preset();
      run_disabled();
      run_preset_fail();
      run_reset();
      print_verdict();
   end
endmodule : tb
